// ==== rtl/flash_block_security_access_consts.vh ====
`ifndef FLASH_BLOCK_SECURITY_ACCESS_CONSTS_VH
`define FLASH_BLOCK_SECURITY_ACCESS_CONSTS_VH

// Command codes; each is a word index, byte address is four times it
`define IDX_CONTROL 8'h00
`define IDX_SUBCLASS 8'h3e
`define IDX_BLOCK_INDEX 8'h3f
`define IDX_WINDOW_FIRST 8'h40
`define IDX_WINDOW_LAST 8'h5f
`define IDX_CHECKSUM 8'h60
`define IDX_SELECTOR 8'h61
`define IDX_UNLOCK_KEY 8'h70
`define IDX_PRIV_KEY 8'h71
`define IDX_STATUS 8'h72

// Security levels
`define LVL_LOCKED 2'h0
`define LVL_UNLOCKED 2'h1
`define LVL_PRIV 2'h2
`define LVL_BOOT 2'h3

// Control subcommands
`define SUB_LOCK 16'h0020
`define SUB_BOOT 16'h0f00

// Maker information area
`define MAKER_SUBCLASS 8'h3a
`define MAKER_BLK_A 8'h01
`define MAKER_BLK_C 8'h03
`define BLOCK_BYTES 6'h20
`define CHECK_BASE 8'hff

// Key reset values, arbitrary
`define UNLOCK_KEY_RST 32'h3672_0414
`define PRIV_KEY_RST 32'hffff_ffff

// Status register field positions
`define ST_LOCKED 2
`define ST_PRIV_LOCKED 3
`define ST_BUSY 4
`define ST_OK 5
`define ST_ERR 6
`define ST_REFUSED 7

`endif

// ==== rtl/flash_block_security_access.v ====
// Contract
// - Stored values are never range checked or rejected.
// - A 32-byte maker information area is kept in the nonvolatile store.
// - Unlocked with selector zero: select subclass, then block, then edit.
// - Window goes to the store only after a verified commit checksum.
// - General access reaches the maker area as subclass 58, offsets 0-31.
// - Locked or selector non-zero: block index 1..3 loads maker A, B, C.
// - In that style a good checksum stores the window to the chosen block.
// - Locked level may read maker block A but never modify it.
// - Store access is gated by level; boot-loader level has none.
// - Only privileged level enters boot-loader level or takes new keys.
// - Unlocked and privileged levels need two key words back to back on control; lock and boot subcommands take one word.
// - Locked flag is set while locked, cleared by the unlock key pair.
// - Privileged key pair clears the privileged-locked flag.
// - Keys are two 16-bit words each, writable only when privileged.
// - Checksum is 255 minus the 8-bit sum of the 32 window bytes.
// - Selector zero at code 0x61 enables general subclass access.
// - Subclass select sits at code 0x3E.
// - Block index sits at code 0x3F and picks the 32-byte block.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "flash_block_security_access_consts.vh"

module flash_block_security_access (
   input wire core_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr
);

   localparam ST_IDLE = 2'h0;
   localparam ST_LOAD = 2'h1;
   localparam ST_STORE = 2'h2;
   localparam TGT_NONE = 2'h0;
   localparam TGT_GEN = 2'h1;
   localparam TGT_MAKER = 2'h2;

   // Nonvolatile contents: 8 general block slots and maker blocks A..C
   reg [7:0] gen_mem [0:255];
   reg [7:0] maker_mem [0:95];
   reg [7:0] window_bytes [0:31];
   reg [7:0] block_access_selector;
   reg [7:0] subclass_select;
   reg [1:0] level;
   reg privileged_locked_flag;
   reg key_seq;
   reg [31:0] unlock_key;
   reg [31:0] priv_key;
   reg [1:0] tgt_kind;
   reg [2:0] tgt_slot;
   reg [1:0] tgt_maker;
   reg [1:0] state;
   reg [4:0] cnt;
   reg busy_q;
   reg commit_ok;
   reg commit_err;
   reg commit_refused;
   reg [7:0] sum;
   reg [31:0] next_prdata;
   reg [31:0] key_exp;
   integer i;
   integer j;

   wire busy = (state != ST_IDLE);
   wire [7:0] idx = paddr[9:2];
   wire addr_hi_zero = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
   wire in_window = (idx >= `IDX_WINDOW_FIRST) && (idx <= `IDX_WINDOW_LAST);
   wire mapped = addr_hi_zero && (in_window || idx == `IDX_CONTROL ||
      idx == `IDX_SUBCLASS || idx == `IDX_BLOCK_INDEX ||
      idx == `IDX_CHECKSUM || idx == `IDX_SELECTOR ||
      idx == `IDX_UNLOCK_KEY || idx == `IDX_PRIV_KEY ||
      idx == `IDX_STATUS);
   wire [4:0] win_off = idx[4:0];
   wire wr_done = psel && penable && pready && pwrite && mapped;
   wire [15:0] wdata16 = pwdata[15:0];
   wire [7:0] wdata8 = pwdata[7:0];
   wire locked_flag = (level == `LVL_LOCKED);
   wire boot = (level == `LVL_BOOT);
   // General style only when unlocked or privileged with selector zero
   wire general_style = (level == `LVL_UNLOCKED || level == `LVL_PRIV) &&
      (block_access_selector == 8'h00);
   wire [7:0] check_value = `CHECK_BASE - sum;
   wire [7:0] gen_addr = {tgt_slot, cnt};
   wire [1:0] maker_sel = tgt_maker - 2'h1;
   wire [6:0] maker_addr = {maker_sel, cnt};

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: a read value is built one cycle ahead, so a stall is held
   // for a cycle after a copy ends to let prdata catch up with the window
   assign pready = !(busy || busy_q);
   assign pslverr = psel && penable && pready && !mapped;

   // 8-bit modular sum of the whole window
   always @* begin
      sum = 8'h00;
      for (i = 0; i < 32; i = i + 1) begin
         sum = sum + window_bytes[i];
      end
   end

   // Read mux; boot-loader level sees no store data
   always @* begin
      next_prdata = 32'h0000_0000;
      if (in_window) begin
         if (!boot) begin
            next_prdata = {24'h00_0000, window_bytes[win_off]};
         end
      end else begin
         case (idx)
            `IDX_SUBCLASS: next_prdata = {24'h00_0000, subclass_select};
            `IDX_BLOCK_INDEX: next_prdata = {24'h00_0000, 5'h00, tgt_maker,
               tgt_slot[0]};
            `IDX_CHECKSUM: next_prdata = {24'h00_0000, check_value};
            `IDX_SELECTOR: next_prdata = {24'h00_0000, block_access_selector};
            `IDX_UNLOCK_KEY: next_prdata = unlock_key;
            `IDX_PRIV_KEY: next_prdata = priv_key;
            `IDX_STATUS: next_prdata = {24'h00_0000, commit_refused,
               commit_err, commit_ok, busy, privileged_locked_flag,
               locked_flag, level};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
         busy_q <= 1'b0;
      end else begin
         prdata <= next_prdata;
         busy_q <= busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Expected key pair depends on the level being left
   always @* begin
      if (level == `LVL_LOCKED) begin
         key_exp = unlock_key;
      end else begin
         key_exp = priv_key;
      end
   end

   // Security level, key tracker and key storage
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         level <= `LVL_LOCKED;
         privileged_locked_flag <= 1'b1;
         key_seq <= 1'b0;
         unlock_key <= `UNLOCK_KEY_RST;
         priv_key <= `PRIV_KEY_RST;
      end else if (wr_done) begin
         if (idx == `IDX_CONTROL) begin
            // Any control write not matching the next key voids the pair
            key_seq <= 1'b0;
            if (key_seq) begin
               if (wdata16 == {key_exp[23:16], key_exp[31:24]}) begin
                  if (level == `LVL_LOCKED) begin
                     level <= `LVL_UNLOCKED;
                  end else if (level == `LVL_UNLOCKED) begin
                     level <= `LVL_PRIV;
                     privileged_locked_flag <= 1'b0;
                  end
               end
            end else if ((level == `LVL_LOCKED || level == `LVL_UNLOCKED) &&
               wdata16 == {key_exp[7:0], key_exp[15:8]}) begin
               key_seq <= 1'b1;
            end else if (wdata16 == `SUB_BOOT) begin
               if (level == `LVL_PRIV) begin
                  level <= `LVL_BOOT;
               end
            end else if (wdata16 == `SUB_LOCK && !boot) begin
               level <= `LVL_LOCKED;
               privileged_locked_flag <= 1'b1;
            end
         end else begin
            key_seq <= 1'b0; // Only control words form a key pair
            // New keys are taken in privileged level alone
            if (level == `LVL_PRIV && idx == `IDX_UNLOCK_KEY) begin
               unlock_key <= pwdata;
            end
            if (level == `LVL_PRIV && idx == `IDX_PRIV_KEY) begin
               priv_key <= pwdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Block selection, commit check and copy sequencer
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         block_access_selector <= 8'h00;
         subclass_select <= 8'h00;
         tgt_kind <= TGT_NONE;
         tgt_slot <= 3'h0;
         tgt_maker <= 2'h0;
         state <= ST_IDLE;
         cnt <= 5'h00;
         commit_ok <= 1'b0;
         commit_err <= 1'b0;
         commit_refused <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wr_done && idx == `IDX_SELECTOR) begin
                  block_access_selector <= wdata8;
               end
               if (wr_done && idx == `IDX_SUBCLASS) begin
                  subclass_select <= wdata8;
               end
               if (wr_done && idx == `IDX_BLOCK_INDEX && !boot) begin
                  cnt <= 5'h00;
                  if (general_style) begin
                     state <= ST_LOAD;
                     if (subclass_select == `MAKER_SUBCLASS &&
                        wdata8 == 8'h00) begin
                        tgt_kind <= TGT_MAKER;
                        tgt_maker <= 2'h1;
                     end else begin
                        tgt_kind <= TGT_GEN;
                        tgt_slot <= {subclass_select[1:0], wdata8[0]};
                        tgt_maker <= 2'h0;
                     end
                  end else if (wdata8 >= `MAKER_BLK_A &&
                     wdata8 <= `MAKER_BLK_C) begin
                     tgt_kind <= TGT_MAKER;
                     tgt_maker <= wdata8[1:0];
                     state <= ST_LOAD;
                  end else begin
                     tgt_kind <= TGT_NONE;
                     tgt_maker <= 2'h0;
                  end
               end
               if (wr_done && idx == `IDX_CHECKSUM) begin
                  commit_ok <= 1'b0;
                  commit_err <= 1'b0;
                  commit_refused <= 1'b0;
                  cnt <= 5'h00;
                  if (boot || tgt_kind == TGT_NONE) begin
                     commit_refused <= 1'b1;
                  end else if (locked_flag && tgt_kind == TGT_GEN) begin
                     // A general block loaded before locking stays read-only
                     commit_refused <= 1'b1;
                  end else if (locked_flag && tgt_maker == 2'h1) begin
                     commit_refused <= 1'b1;
                  end else if (wdata8 == check_value) begin
                     commit_ok <= 1'b1;
                     state <= ST_STORE;
                  end else begin
                     commit_err <= 1'b1;
                  end
               end
            end
            ST_LOAD, ST_STORE: begin
               cnt <= cnt + 5'h01;
               if (cnt == 5'h1f) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Window bytes: host edits in idle, block copy while loading
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (j = 0; j < 32; j = j + 1) begin
            window_bytes[j] <= 8'h00;
         end
      end else if (state == ST_LOAD) begin
         if (tgt_kind == TGT_MAKER) begin
            window_bytes[cnt] <= maker_mem[maker_addr];
         end else begin
            window_bytes[cnt] <= gen_mem[gen_addr];
         end
      end else if (wr_done && in_window && !boot) begin
         // Any value is taken as written; legality is the host's concern
         window_bytes[win_off] <= wdata8;
      end
   end

   // Store write-back; no reset, the contents model nonvolatile cells
   always @(posedge core_clk) begin
      if (state == ST_STORE) begin
         if (tgt_kind == TGT_MAKER) begin
            maker_mem[maker_addr] <= window_bytes[cnt];
         end else begin
            gen_mem[gen_addr] <= window_bytes[cnt];
         end
      end
   end

endmodule // flash_block_security_access

// ==== tb/bus_rules_checker.sv ====
`timescale 1ns/1ps
module bus_rules_checker (
   input wire core_clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // Completed transfer and completed status read
   wire acc = psel && penable && pready;
   wire rd_st = acc && !pwrite && paddr == 12'h1c8;
   ////////////////////////////////////////////////////////////////////////
   a_err_unmapped: assert property (acc && paddr[11:10] != 2'h0 |-> pslverr)
      else $error("unmapped access not flagged");
   a_no_reject: assert property (acc && paddr <= 12'h1c8 |-> !pslverr)
      else $error("mapped access rejected");
   a_stall_cause: assert property ($fell(pready) |->
      $past(acc && pwrite && (paddr == 12'h0fc || paddr == 12'h180)))
      else $error("stall without load or commit");
   a_stall_len: assert property ($fell(pready) |->
      !pready [*8] ##[20:30] pready)
      else $error("stall length wrong");
   a_byte_width: assert property (acc && !pwrite && paddr >= 12'h100 &&
      paddr <= 12'h180 |-> prdata[31:8] == 24'h0)
      else $error("window byte wider than 8 bits");
   a_lock_flag: assert property (rd_st && prdata[1:0] == 2'h0 |-> prdata[2])
      else $error("locked flag clear while locked");
   a_unlock_clr: assert property (rd_st && prdata[1:0] == 2'h1 |->
      !prdata[2] && prdata[3])
      else $error("flags wrong while unlocked");
   a_priv_clr: assert property (rd_st && prdata[1:0] == 2'h2 |->
      prdata[3:2] == 2'h0)
      else $error("flags wrong while privileged");
   a_commit_one: assert property (rd_st |-> $onehot0(prdata[7:5]))
      else $error("more than one commit outcome");
   // Main scenarios reached
   c_priv: cover property (rd_st && prdata[1:0] == 2'h2);
   c_stall: cover property ($fell(pready));
   c_unmapped: cover property (acc && pslverr);
endmodule // bus_rules_checker

bind flash_block_security_access bus_rules_checker bus_rules_checker_inst (
   .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// ==== tb/host_apb_master.sv ====
`timescale 1ns/1ps
module host_apb_master (
   input wire core_clk,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   // Error answer of the last completed transfer
   logic err;
   // Bus idle at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Request held until ready is seen high at a rising edge; data and
   // error answer are taken at that same edge, then the bus is released
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (!pready) begin
         @(posedge core_clk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Key words go out byte swapped, back to back; keys avoid subcommands
   task send_key(input logic [31:0] k);
      logic [31:0] q;
      xfer(1'b1, 12'h000, {16'h0, k[7:0], k[15:8]}, q);
      xfer(1'b1, 12'h000, {16'h0, k[23:16], k[31:24]}, q);
   endtask
endmodule // host_apb_master

// ==== tb/flash_block_security_access_tb_top.sv ====
`timescale 1ns/1ps
module flash_block_security_access_tb_top;
   logic core_clk, rst;
   wire psel, penable, pwrite, pready, pslverr;
   wire [11:0] paddr;
   wire [31:0] pwdata, prdata;
   logic [31:0] q;
   logic [7:0] sum;
   int num_errors = 0;
   int n_checks = 0;
   flash_block_security_access flash_block_security_access_inst (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   host_apb_master host_apb_master_inst (.core_clk(core_clk),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task wr(input logic [11:0] a, input logic [31:0] d);
      host_apb_master_inst.xfer(1'b1, a, d, q);
   endtask
   task rd(input logic [11:0] a);
      host_apb_master_inst.xfer(1'b0, a, 32'h0, q);
   endtask
   task key(input logic [31:0] k);
      host_apb_master_inst.send_key(k);
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task st(input logic [31:0] e, input logic [31:0] m);
      rd(12'h1c8);
      chk("status", e, q & m);
   endtask
   task final_report;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      final_report;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      st(32'h0c, 32'hff);
      wr(12'h0fc, 32'h1);
      wr(12'h180, 32'h0);
      st(32'h8c, 32'hff);
      key(32'h1111_0414);
      st(32'h8c, 32'hff);
      key(32'h3672_0414);
      st(32'h89, 32'hff);
      // Pair broken by another write, then restarted and broken by a boot code taken as second key word
      wr(12'h000, 32'hffff);
      wr(12'h184, 32'h0);
      wr(12'h000, 32'hffff);
      wr(12'h000, 32'h0f00);
      st(32'h89, 32'hff);
      // Tracker idle again: this one is a plain boot request, refused
      wr(12'h000, 32'h0f00);
      st(32'h89, 32'hff);
      // General style edit of the maker area, whole block so no gaps
      wr(12'h0f8, 32'h3a);
      wr(12'h0fc, 32'h0);
      sum = 8'h0;
      for (int i = 0; i < 32; i++) begin
         wr(12'(12'h100 + 4 * i), 32'(i * 7 + 3));
         sum = sum + 8'(i * 7 + 3);
      end
      rd(12'h180);
      chk("checksum", {24'h0, 8'hff - sum}, q);
      wr(12'h180, {24'h0, 8'hff - sum + 8'h1});
      st(32'h49, 32'hff);
      rd(12'h114);
      chk("window", 32'd38, q);
      wr(12'h180, {24'h0, 8'hff - sum});
      st(32'h29, 32'hff);
      // Block select style now shows the committed maker block
      wr(12'h184, 32'h1);
      wr(12'h0fc, 32'h1);
      rd(12'h10c);
      chk("maker block", 32'd24, q);
      key(32'hffff_ffff);
      st(32'h22, 32'hff);
      wr(12'h1c0, 32'h5678_1234);
      wr(12'h000, 32'h0020);
      st(32'h2c, 32'hff);
      wr(12'h1c0, 32'h0);
      key(32'h5678_1234);
      st(32'h29, 32'hff);
      key(32'hffff_ffff);
      wr(12'h000, 32'h0f00);
      st(32'h03, 32'h03);
      rd(12'h100);
      chk("boot window", 32'h0, q);
      chk("mapped error", 32'h0, {31'h0, host_apb_master_inst.err});
      rd(12'h800);
      chk("unmapped error", 32'h1, {31'h0, host_apb_master_inst.err});
      final_report;
   end
endmodule // flash_block_security_access_tb_top
